/* rtl/sfa_pkg.sv */
// Purpose: Constants and beat carriers for the stream format adapter
// Assumes: One symbol count divides the other evenly
// Notes: Edit the build-time settings here to reshape the adapter

`default_nettype none

package sfa_pkg;

	// Build-time stream shape
	localparam int SYM_BITS = 8;
	localparam int IN_SYMBOLS = 4;
	localparam int OUT_SYMBOLS = 2;
	localparam bit HAS_PACKETS = 1'b1;
	localparam bit IN_HAS_EMPTY = 1'b1;
	localparam bit OUT_HAS_EMPTY = 1'b1;
	localparam int CHAN_W = 2;
	localparam int MAX_CHAN = 3;
	localparam int ERR_W = 2;
	localparam int READY_LAT = 1; // Must be 1 or more
	localparam int IN_EMPTY_W = (IN_SYMBOLS > 1) ? $clog2(IN_SYMBOLS) : 1;
	localparam int OUT_EMPTY_W = (OUT_SYMBOLS > 1) ? $clog2(OUT_SYMBOLS) : 1;
	localparam int RDY_HIST = (READY_LAT > 1) ? READY_LAT - 1 : 1;
	localparam int RDY_SEL = (READY_LAT > 1) ? READY_LAT - 2 : 0;

	// Register map, byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IN_BEATS = 8'h08;
	localparam logic [7:0] OFS_OUT_BEATS = 8'h0C;
	localparam logic [7:0] OFS_CONFIG = 8'h10;
	localparam int CTRL_CLEAR_BIT = 0;
	localparam logic [31:0] COUNT_RST = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [IN_SYMBOLS*SYM_BITS-1:0] data;
		logic sop;
		logic eop;
		logic [IN_EMPTY_W-1:0] empty;
		logic [CHAN_W-1:0] chan;
		logic [ERR_W-1:0] err;
	} sfa_in_beat_s;

	typedef struct packed {
		logic [OUT_SYMBOLS*SYM_BITS-1:0] data;
		logic sop;
		logic eop;
		logic [OUT_EMPTY_W-1:0] empty;
		logic [CHAN_W-1:0] chan;
		logic [ERR_W-1:0] err;
	} sfa_out_beat_s;

endpackage : sfa_pkg

`default_nettype wire

/* rtl/sfa_adapter.sv */
// Purpose: Stream width adapter with beat counters on AXI4-Lite
// Assumes: Single clock, sync reset, ready latency of one or more
// Notes: First symbol of a beat sits in the most significant bits
//
// What this block does
// - Repack beats so output carries the downstream symbol count.
// - Wide to narrow: each input beat leaves as consecutive narrow beats.
// - Wide to narrow: input error repeats on every derived output beat.
// - Narrow to wide: gather input beats into one output beat, closed early at packet end.
// - Narrow to wide: output error is OR of merged input errors.
// - With packets on, first, last and empty travel both sides.
// - Output honours set ready latency; sink backpressures with that latency.
// - Symbols and empty presence set per side; symbol width shared.
// - Channel width, top channel and error width are build settings.
// - Ready latency counts cycles from ready to allowed valid.

`timescale 1ns/1ns
`default_nettype none

module sfa_adapter (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire sfa_pkg::sfa_in_beat_s in_beat,
	output logic out_valid,
	input wire logic out_ready,
	output sfa_pkg::sfa_out_beat_s out_beat,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam int IN = sfa_pkg::IN_SYMBOLS;
	localparam int OUT = sfa_pkg::OUT_SYMBOLS;
	localparam int SB = sfa_pkg::SYM_BITS; // Shared by both sides
	localparam int OEW = sfa_pkg::OUT_EMPTY_W;
	localparam int IEW = sfa_pkg::IN_EMPTY_W;

	logic in_ready_q;
	logic out_valid_q;
	sfa_pkg::sfa_out_beat_s out_beat_q;
	logic [sfa_pkg::RDY_HIST-1:0] rdy_hist_q;
	logic ready_sel;
	logic take;
	logic emit;
	logic busy;
	logic in_eop;
	logic [IEW-1:0] in_empty;

	assign in_ready = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_beat = out_beat_q;
	assign take = in_valid && in_ready_q;
	// End flag ignored when the build has no packets; empty ignored when IN_HAS_EMPTY is off
	assign in_eop = sfa_pkg::HAS_PACKETS && in_beat.eop;
	assign in_empty = sfa_pkg::IN_HAS_EMPTY ? in_beat.empty : '0;

	// Ready history; a beat may appear only where ready was seen
	// exactly the latency earlier, so the sink never gets a surprise
	always_ff @(posedge clk) begin
		if (rst) begin
			rdy_hist_q <= '0;
		end else begin
			rdy_hist_q[0] <= out_ready;
			for (int k = 1; k < sfa_pkg::RDY_HIST; k++) begin
				rdy_hist_q[k] <= rdy_hist_q[k-1];
			end
		end
	end

	// Decided one edge early, so this looks latency minus one back
	assign ready_sel = (sfa_pkg::READY_LAT == 1) ? out_ready :
		rdy_hist_q[sfa_pkg::RDY_SEL];

	generate
		if (IN > OUT) begin : g_split
			localparam int N = IN / OUT;
			localparam int IW = (N > 1) ? $clog2(N) : 1;
			sfa_pkg::sfa_in_beat_s hold_q;
			logic hold_v_q;
			logic [IW-1:0] idx_q;
			logic [7:0] vs_c;
			logic [7:0] pieces_c;
			logic last_c;
			logic [IN*SB-1:0] shifted_c;

			// Pieces needed for the symbols really present
			always_comb begin
				vs_c = 8'(IN);
				if (hold_q.eop && sfa_pkg::IN_HAS_EMPTY) begin
					vs_c = 8'(IN) - 8'(hold_q.empty);
				end
				pieces_c = (vs_c + 8'(OUT - 1)) / 8'(OUT);
				last_c = (8'(idx_q) == pieces_c - 8'h01);
				shifted_c = hold_q.data << (int'(idx_q) * OUT * SB);
			end

			assign emit = hold_v_q && ready_sel;
			assign busy = hold_v_q;

			// Hold one wide beat and walk through its pieces
			always_ff @(posedge clk) begin
				if (rst) begin
					hold_v_q <= 1'b0;
					idx_q <= '0;
					hold_q <= '0;
				end else if (take) begin
					hold_q <= in_beat;
					hold_q.eop <= in_eop;
					hold_q.empty <= in_empty;
					hold_v_q <= 1'b1;
					idx_q <= '0;
				end else if (emit) begin
					if (last_c) begin
						hold_v_q <= 1'b0;
					end else begin
						idx_q <= idx_q + 1'b1;
					end
				end
			end

			// Refuse new input until the last piece has left
			always_ff @(posedge clk) begin
				if (rst) begin
					in_ready_q <= 1'b1;
				end else if (take) begin
					in_ready_q <= 1'b0;
				end else if (emit && last_c) begin
					in_ready_q <= 1'b1;
				end
			end

			// Output stage, one piece per permitted cycle
			always_ff @(posedge clk) begin
				if (rst) begin
					out_valid_q <= 1'b0;
					out_beat_q <= '0;
				end else begin
					out_valid_q <= emit;
					if (emit) begin
						out_beat_q.data <= shifted_c[IN*SB-1 -: OUT*SB];
						out_beat_q.sop <= hold_q.sop && (idx_q == '0);
						out_beat_q.eop <= hold_q.eop && last_c;
						out_beat_q.empty <= '0;
						if (last_c && sfa_pkg::OUT_HAS_EMPTY) begin
							out_beat_q.empty <= OEW'(pieces_c * 8'(OUT) - vs_c);
						end
						out_beat_q.chan <= hold_q.chan;
						out_beat_q.err <= hold_q.err; // Same error every piece
					end
				end
			end
		end else begin : g_gather
			localparam int N = OUT / IN;
			localparam int CW = $clog2(N + 1);
			logic [OUT*SB-1:0] acc_q;
			logic [CW-1:0] cnt_q;
			logic full_q;
			logic sop_q;
			logic eop_q;
			logic [OEW-1:0] empty_q;
			logic [sfa_pkg::CHAN_W-1:0] chan_q;
			logic [sfa_pkg::ERR_W-1:0] err_q;
			logic closes;

			// Beat closes when full or when the packet ends early
			assign closes = (int'(cnt_q) == N - 1) || in_eop;
			assign emit = full_q && ready_sel;
			assign busy = full_q || (cnt_q != '0);

			// Accumulate narrow beats into the wide word
			always_ff @(posedge clk) begin
				if (rst) begin
					acc_q <= '0;
					cnt_q <= '0;
					full_q <= 1'b0;
					sop_q <= 1'b0;
					eop_q <= 1'b0;
					empty_q <= '0;
					chan_q <= '0;
					err_q <= '0;
				end else if (emit) begin
					cnt_q <= '0;
					full_q <= 1'b0;
					err_q <= '0;
				end else if (take) begin
					acc_q[(N - 1 - int'(cnt_q)) * IN * SB +: IN * SB] <= in_beat.data;
					cnt_q <= cnt_q + 1'b1;
					err_q <= err_q | in_beat.err;
					full_q <= closes;
					eop_q <= in_eop;
					empty_q <= '0;
					if (in_eop) begin
						empty_q <= OEW'((N - 1 - int'(cnt_q)) * IN + int'(in_empty));
					end
					if (cnt_q == '0) begin
						sop_q <= sfa_pkg::HAS_PACKETS && in_beat.sop;
						chan_q <= in_beat.chan; // First beat's channel
					end
				end
			end

			// Stall input while a finished wide beat waits
			always_ff @(posedge clk) begin
				if (rst) begin
					in_ready_q <= 1'b1;
				end else if (take && closes) begin
					in_ready_q <= 1'b0;
				end else if (emit) begin
					in_ready_q <= 1'b1;
				end
			end

			// Output stage for the gathered beat
			always_ff @(posedge clk) begin
				if (rst) begin
					out_valid_q <= 1'b0;
					out_beat_q <= '0;
				end else begin
					out_valid_q <= emit;
					if (emit) begin
						out_beat_q.data <= acc_q;
						out_beat_q.sop <= sop_q;
						out_beat_q.eop <= eop_q;
						out_beat_q.empty <= sfa_pkg::OUT_HAS_EMPTY ? empty_q : '0;
						out_beat_q.chan <= chan_q;
						out_beat_q.err <= err_q;
					end
				end
			end
		end
	endgenerate

	// Register bus state
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [31:0] in_cnt_q;
	logic [31:0] out_cnt_q;
	logic clear_c;

	assign clear_c = aw_have_q && w_have_q && !s_axi_bvalid &&
		(aw_addr_q == sfa_pkg::OFS_CTRL) && w_strb_q[0] &&
		w_data_q[sfa_pkg::CTRL_CLEAR_BIT];

	// Beat counters; a beat in the clearing cycle still counts
	always_ff @(posedge clk) begin
		if (rst) begin
			in_cnt_q <= sfa_pkg::COUNT_RST;
			out_cnt_q <= sfa_pkg::COUNT_RST;
		end else begin
			if (clear_c) begin
				in_cnt_q <= {31'h0000_0000, take};
				out_cnt_q <= {31'h0000_0000, out_valid_q};
			end else begin
				in_cnt_q <= in_cnt_q + {31'h0000_0000, take};
				out_cnt_q <= out_cnt_q + {31'h0000_0000, out_valid_q};
			end
		end
	end

	// Write path: address and data taken in either order
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sfa_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_q == sfa_pkg::OFS_CTRL) ?
					sfa_pkg::RESP_OKAY : sfa_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read path, one read at a time
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= sfa_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= sfa_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				sfa_pkg::OFS_CTRL: s_axi_rdata <= 32'h0000_0000;
				sfa_pkg::OFS_STATUS: s_axi_rdata <= {29'h0000_0000,
					out_valid_q, busy, in_ready_q};
				sfa_pkg::OFS_IN_BEATS: s_axi_rdata <= in_cnt_q;
				sfa_pkg::OFS_OUT_BEATS: s_axi_rdata <= out_cnt_q;
				sfa_pkg::OFS_CONFIG: s_axi_rdata <= {8'(SB), 8'(OUT), 8'(IN),
					8'(sfa_pkg::READY_LAT)};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= sfa_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : sfa_adapter

`default_nettype wire

/* verif/sfa_adapter_props.sv */
// Purpose: Concurrent checks on the stream adapter ports
// Assumes: Split build, ready latency of one
// Notes: Last accepted input beat is kept to judge its pieces
`timescale 1ns/1ns
`default_nettype none
module sfa_adapter_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire sfa_pkg::sfa_in_beat_s in_beat,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire sfa_pkg::sfa_out_beat_s out_beat,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sfa_pkg::sfa_in_beat_s held_q;
	// Source of every piece now leaving
	always_ff @(posedge clk) begin
		if (rst)
			held_q <= '0;
		else if (in_valid && in_ready)
			held_q <= in_beat;
	end
	rdy_lat_a: assert property (out_valid |-> $past(out_ready))
		else $error("valid without ready one cycle before");
	take_stall_a: assert property (in_valid && in_ready |=> !in_ready)
		else $error("input still ready after a take");
	input_drain_a: assert property ((!in_ready && out_ready) [*4] |=> in_ready)
		else $error("input stalled too long");
	err_copy_a: assert property (out_valid |-> out_beat.err == held_q.err)
		else $error("piece error differs from input");
	chan_pass_a: assert property (out_valid |-> out_beat.chan == held_q.chan)
		else $error("piece channel differs from input");
	sop_first_a: assert property (out_valid && out_beat.sop |-> held_q.sop
		&& out_beat.data == held_q.data[31:16])
		else $error("first piece wrong");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered next cycle");
endmodule : sfa_adapter_props
`default_nettype wire

/* verif/sfa_sink_model.sv */
// Purpose: Downstream sink that applies backpressure
// Assumes: Same symbol width as the adapter, empty port present
// Notes: Slow mode drops ready on about a third of cycles
`timescale 1ns/1ns
`default_nettype none
module sfa_sink_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	output logic out_ready
);
	int seed = 32'h667f;
	// Ready is a promise for the beat one cycle later
	always @(posedge clk) begin
		out_ready <= !rst && (!slow || ($random(seed) % 3 != 0));
	end
endmodule : sfa_sink_model
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the stream adapter
// Assumes: Split build from the package
// Notes: Expected pieces come from a queue model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks += 1; if ((a) !== (b)) begin \
	num_errors += 1; $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
	logic clk = 1'b0, rst = 1'b1, in_valid = 1'b0, out_valid, in_ready;
	logic out_ready, slow = 1'b0;
	sfa_pkg::sfa_in_beat_s in_beat = '0;
	sfa_pkg::sfa_out_beat_s out_beat, e, exp_q[$];
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int num_errors = 0, total_checks = 0, seed = 32'h667f, n_in = 0, n_out = 0;
	sfa_adapter u_dut (.clk, .rst, .in_valid, .in_ready, .in_beat, .out_valid,
		.out_ready, .out_beat, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	sfa_sink_model u_sink (.clk, .rst, .slow, .out_ready);
	always #10 clk = ~clk;
	task print_verdict;
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// Split one input beat into the pieces it must yield
	function automatic void push(sfa_pkg::sfa_in_beat_s b);
		int p, n;
		sfa_pkg::sfa_out_beat_s o;
		p = sfa_pkg::IN_SYMBOLS - (b.eop ? int'(b.empty) : 0);
		n = (p + sfa_pkg::OUT_SYMBOLS - 1) / sfa_pkg::OUT_SYMBOLS;
		for (int k = 0; k < n; k++) begin
			o.data = b.data[31 - 16 * k -: 16];
			o.sop = b.sop && k == 0;
			o.eop = b.eop && k == n - 1;
			o.empty = o.eop ? 1'(n * sfa_pkg::OUT_SYMBOLS - p) : 1'b0;
			o.chan = b.chan;
			o.err = b.err;
			exp_q.push_back(o);
			n_out++;
		end
	endfunction : push
	// Compare each emitted piece before queueing new ones
	always @(posedge clk) begin
		if (!rst && out_valid) begin
			e = exp_q.size() ? exp_q.pop_front() : 'x;
			`CHK(out_beat, e)
		end
		if (!rst && in_valid && in_ready) begin
			push(in_beat);
			n_in++;
		end
	end
	task send(sfa_pkg::sfa_in_beat_s b);
		int i;
		in_valid <= 1'b1;
		in_beat <= b;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (in_ready) break;
		end
		if (i == 200) begin num_errors++; print_verdict; end
	endtask : send
	task wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
		int i;
		// Response ready raised late, so a waiting response must hold
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		if (i == 50) begin num_errors++; print_verdict; end
		`CHK(s_axi_bresp, r)
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	task rd(logic [7:0] a, logic [31:0] d, logic [1:0] r);
		int i;
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (i == 50) begin num_errors++; print_verdict; end
		`CHK(s_axi_rdata, d)
		`CHK(s_axi_rresp, r)
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	// Packets of 1..3 beats, every empty count, prompt and slow sink
	initial begin
		sfa_pkg::sfa_in_beat_s b;
		int len, i;
		logic [31:0] cfg;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int p = 0; p < 24; p++) begin
			slow <= (p / 4) % 2 == 1;
			len = 1 + p % 3;
			for (int k = 0; k < len; k++) begin
				b.data = $random(seed);
				b.sop = k == 0;
				b.eop = k == len - 1;
				b.empty = b.eop ? 2'(p % 4) : 2'h0;
				b.chan = 2'(p);
				b.err = 2'($random(seed));
				send(b);
			end
		end
		in_valid <= 1'b0;
		for (i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge clk);
		`CHK(exp_q.size(), 0)
		if (exp_q.size() > 0) print_verdict;
		rd(sfa_pkg::OFS_IN_BEATS, n_in, sfa_pkg::RESP_OKAY);
		rd(sfa_pkg::OFS_OUT_BEATS, n_out, sfa_pkg::RESP_OKAY);
		// Clear lives in byte lane 0; without that lane counts survive
		s_axi_wstrb <= 4'hE;
		wr(sfa_pkg::OFS_CTRL, 32'h1, sfa_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(sfa_pkg::OFS_IN_BEATS, n_in, sfa_pkg::RESP_OKAY);
		wr(sfa_pkg::OFS_CTRL, 32'h1, sfa_pkg::RESP_OKAY);
		rd(sfa_pkg::OFS_IN_BEATS, 32'h0, sfa_pkg::RESP_OKAY);
		rd(sfa_pkg::OFS_OUT_BEATS, 32'h0, sfa_pkg::RESP_OKAY);
		rd(sfa_pkg::OFS_CTRL, 32'h0, sfa_pkg::RESP_OKAY);
		// Idle: input ready, nothing held, no beat leaving
		rd(sfa_pkg::OFS_STATUS, 32'h0000_0001, sfa_pkg::RESP_OKAY);
		cfg = {8'(sfa_pkg::SYM_BITS), 8'(sfa_pkg::OUT_SYMBOLS),
			8'(sfa_pkg::IN_SYMBOLS), 8'(sfa_pkg::READY_LAT)};
		rd(sfa_pkg::OFS_CONFIG, cfg, sfa_pkg::RESP_OKAY);
		wr(sfa_pkg::OFS_IN_BEATS, 32'h5, sfa_pkg::RESP_SLVERR);
		wr(8'h40, 32'h0, sfa_pkg::RESP_SLVERR);
		rd(8'h14, 32'h0, sfa_pkg::RESP_SLVERR);
		print_verdict;
	end
endmodule : tb
bind sfa_adapter sfa_adapter_props u_props (.clk, .rst, .in_valid, .in_ready,
	.in_beat, .out_valid, .out_ready, .out_beat, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire
